//--- lmsc_pkg.sv
package lmsc_pkg;

	localparam int unsigned PIN_W = 6;
	localparam logic [1:0] WAKE_FS_EDGES = 2'h3;

	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_INT_STAT = 12'h008;
	localparam logic [11:0] ADDR_INT_MASK = 12'h00c;

	localparam int unsigned CTRL_MOD_EN_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h00000001;
	localparam logic [3:0] INT_MASK_RESET = 4'h0;

	localparam int unsigned ST_POWERED_BIT = 0;
	localparam int unsigned ST_WAKING_BIT = 1;
	localparam int unsigned ST_ARMED_BIT = 2;
	localparam int unsigned ST_RUN_BIT = 3;
	localparam int unsigned ST_VALID_BIT = 4;
	localparam int unsigned ST_RX_FIRST_BIT = 5;
	localparam int unsigned ST_RX_SECOND_BIT = 6;
	localparam int unsigned ST_TX_FIRST_BIT = 7;
	localparam int unsigned ST_TX_SECOND_BIT = 8;
	localparam int unsigned ST_INSERT_BIT = 9;
	localparam int unsigned ST_PORT_EN_BIT = 10;

	localparam int unsigned INT_W = 4;
	localparam int unsigned IRQ_FRAME_BIT = 0;
	localparam int unsigned IRQ_DEMOD_BIT = 1;
	localparam int unsigned IRQ_WAKE_BIT = 2;
	localparam int unsigned IRQ_VALID_LOST_BIT = 3;

	typedef enum logic [1:0] {
		LMSC_DOWN,
		LMSC_WAKE,
		LMSC_ARM,
		LMSC_RUN
	} lmsc_state_t;

	typedef struct packed {
		logic frame_sync;
		logic power_down_bar;
		logic signal_port_enable;
		logic signal_in_first;
		logic signal_in_second;
		logic signal_insert_control;
	} lmsc_pins_t;

	typedef struct packed {
		logic done;
		logic sync_ok;
		logic bit_error;
		logic sig_first;
		logic sig_second;
	} lmsc_demod_t;

	typedef struct packed {
		logic start;
		logic sig_first;
		logic sig_second;
		logic insert;
	} lmsc_mod_t;

	typedef struct packed {
		logic valid_indicator;
		logic signal_out_first;
		logic signal_out_second;
	} lmsc_sig_t;

endpackage : lmsc_pkg

//--- lmsc_top.sv
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module lmsc_top (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	input wire lmsc_pkg::lmsc_pins_t pins_in,
	input wire lmsc_pkg::lmsc_demod_t demod_in,
	output lmsc_pkg::lmsc_mod_t mod_out,
	output logic xfer_enable_out,
	output lmsc_pkg::lmsc_sig_t sig_out,
	output lmsc_pkg::lmsc_sig_t sig_oe_n_out
);

	logic [lmsc_pkg::PIN_W-1:0] s1_r, s2_r, s3_r, filt_r;
	logic [lmsc_pkg::PIN_W-1:0] filt_nxt;
	lmsc_pkg::lmsc_pins_t pins;
	logic fs_prev_r;
	logic fs_rise;

	logic pd_hold_r, si1_hold_r, si2_hold_r, sie_hold_r;
	logic pd_hold_nxt, si1_hold_nxt, si2_hold_nxt, sie_hold_nxt;
	logic pd_eff, si1_eff, si2_eff, sie_eff;

	lmsc_pkg::lmsc_state_t state_r, state_nxt;
	logic [1:0] wake_cnt_r, wake_cnt_nxt;
	logic wake_end;

	lmsc_pkg::lmsc_mod_t mod_r, mod_nxt;
	logic xfer_en_r, xfer_en_nxt;
	lmsc_pkg::lmsc_sig_t pend_r, pend_nxt;
	lmsc_pkg::lmsc_sig_t out_r, out_nxt;
	logic demod_valid;

	logic [31:0] ctrl_r, ctrl_nxt;
	logic [lmsc_pkg::INT_W-1:0] int_stat_r, int_stat_nxt;
	logic [lmsc_pkg::INT_W-1:0] int_mask_r, int_mask_nxt;
	logic [lmsc_pkg::INT_W-1:0] events;
	logic irq_r, irq_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic [31:0] status_word;
	logic setup, wr_take, mapped;

	// Pin synchronisers: a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < lmsc_pkg::PIN_W; gi++) begin : g_sync
			always_comb begin
				filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
			end
		end
	endgenerate

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			filt_r <= '0;
			fs_prev_r <= 1'b0;
		end else begin
			s1_r <= pins_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= filt_nxt;
			fs_prev_r <= pins.frame_sync;
		end
	end

	assign pins = filt_r;
	// Frame sync rise is the main timing reference; demod done also ends wake-up and updates outputs in power-down
	assign fs_rise = pins.frame_sync & ~fs_prev_r;

	// Gated inputs: live while enabled, frozen copy while disabled
	always_comb begin
		pd_hold_nxt = pd_hold_r;
		si1_hold_nxt = si1_hold_r;
		si2_hold_nxt = si2_hold_r;
		sie_hold_nxt = sie_hold_r;
		if (pins.signal_port_enable) begin
			pd_hold_nxt = pins.power_down_bar;
			si1_hold_nxt = pins.signal_in_first;
			si2_hold_nxt = pins.signal_in_second;
			sie_hold_nxt = pins.signal_insert_control;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pd_hold_r <= 1'b0;
			si1_hold_r <= 1'b0;
			si2_hold_r <= 1'b0;
			sie_hold_r <= 1'b0;
		end else begin
			pd_hold_r <= pd_hold_nxt;
			si1_hold_r <= si1_hold_nxt;
			si2_hold_r <= si2_hold_nxt;
			sie_hold_r <= sie_hold_nxt;
		end
	end

	assign pd_eff = pins.signal_port_enable ? pins.power_down_bar : pd_hold_r;
	assign si1_eff = pins.signal_port_enable ? pins.signal_in_first : si1_hold_r;
	assign si2_eff = pins.signal_port_enable ? pins.signal_in_second : si2_hold_r;
	assign sie_eff = pins.signal_port_enable ? pins.signal_insert_control : sie_hold_r;

	// Power and wake-up sequencing
	always_comb begin
		state_nxt = state_r;
		wake_cnt_nxt = wake_cnt_r;
		wake_end = 1'b0;
		if (!pd_eff) begin
			state_nxt = lmsc_pkg::LMSC_DOWN;
			wake_cnt_nxt = 2'h0;
		end else begin
			case (state_r)
				lmsc_pkg::LMSC_DOWN: begin
					state_nxt = lmsc_pkg::LMSC_WAKE;
					wake_cnt_nxt = 2'h0;
				end
				lmsc_pkg::LMSC_WAKE: begin
					if (demod_in.done) begin
						state_nxt = lmsc_pkg::LMSC_ARM;
						wake_end = 1'b1;
					end else if (fs_rise) begin
						wake_cnt_nxt = wake_cnt_r + 2'h1;
						if (wake_cnt_r + 2'h1 == lmsc_pkg::WAKE_FS_EDGES) begin
							state_nxt = lmsc_pkg::LMSC_ARM;
							wake_end = 1'b1;
						end
					end
				end
				lmsc_pkg::LMSC_ARM: begin
					if (fs_rise) begin
						state_nxt = lmsc_pkg::LMSC_RUN;
					end
				end
				lmsc_pkg::LMSC_RUN: begin
					state_nxt = lmsc_pkg::LMSC_RUN;
				end
				default: begin
					state_nxt = lmsc_pkg::LMSC_DOWN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_r <= lmsc_pkg::LMSC_DOWN;
			wake_cnt_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			wake_cnt_r <= wake_cnt_nxt;
		end
	end

	// Modulator request and outgoing signaling latch
	always_comb begin
		mod_nxt = mod_r;
		mod_nxt.start = 1'b0;
		xfer_en_nxt = pd_eff;
		if (fs_rise && pd_eff) begin
			mod_nxt.sig_first = si1_eff;
			mod_nxt.sig_second = si2_eff;
			mod_nxt.insert = sie_eff;
			if ((state_r == lmsc_pkg::LMSC_ARM || state_r == lmsc_pkg::LMSC_RUN)
					&& ctrl_r[lmsc_pkg::CTRL_MOD_EN_BIT]) begin
				mod_nxt.start = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			mod_r <= '0;
			xfer_en_r <= 1'b0;
		end else begin
			mod_r <= mod_nxt;
			xfer_en_r <= xfer_en_nxt;
		end
	end

	// Received signaling and valid indication
	assign demod_valid = demod_in.sync_ok & ~demod_in.bit_error;

	always_comb begin
		pend_nxt = pend_r;
		out_nxt = out_r;
		if (demod_in.done) begin
			pend_nxt.valid_indicator = demod_valid;
			pend_nxt.signal_out_first = demod_in.sig_first;
			pend_nxt.signal_out_second = demod_in.sig_second;
		end
		if (!pd_eff && demod_in.done) begin
			out_nxt = pend_nxt;
		end else if (pd_eff && fs_rise) begin
			out_nxt = pend_r;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pend_r <= '0;
			out_r <= '0;
		end else begin
			pend_r <= pend_nxt;
			out_r <= out_nxt;
		end
	end

	// Interrupt status: set wins over a write-one clear
	assign events[lmsc_pkg::IRQ_FRAME_BIT] = fs_rise;
	assign events[lmsc_pkg::IRQ_DEMOD_BIT] = demod_in.done;
	assign events[lmsc_pkg::IRQ_WAKE_BIT] = wake_end;
	assign events[lmsc_pkg::IRQ_VALID_LOST_BIT] = out_r.valid_indicator & ~out_nxt.valid_indicator;

	// Register bus
	assign setup = psel_in & ~penable_in;
	assign wr_take = psel_in & penable_in & pready_r & pwrite_in;
	assign mapped = (paddr_in == lmsc_pkg::ADDR_CTRL) || (paddr_in == lmsc_pkg::ADDR_STATUS)
		|| (paddr_in == lmsc_pkg::ADDR_INT_STAT) || (paddr_in == lmsc_pkg::ADDR_INT_MASK);

	always_comb begin
		status_word = 32'h00000000;
		status_word[lmsc_pkg::ST_POWERED_BIT] = pd_eff;
		status_word[lmsc_pkg::ST_WAKING_BIT] = (state_r == lmsc_pkg::LMSC_WAKE);
		status_word[lmsc_pkg::ST_ARMED_BIT] = (state_r == lmsc_pkg::LMSC_ARM);
		status_word[lmsc_pkg::ST_RUN_BIT] = (state_r == lmsc_pkg::LMSC_RUN);
		status_word[lmsc_pkg::ST_VALID_BIT] = out_r.valid_indicator;
		status_word[lmsc_pkg::ST_RX_FIRST_BIT] = out_r.signal_out_first;
		status_word[lmsc_pkg::ST_RX_SECOND_BIT] = out_r.signal_out_second;
		status_word[lmsc_pkg::ST_TX_FIRST_BIT] = mod_r.sig_first;
		status_word[lmsc_pkg::ST_TX_SECOND_BIT] = mod_r.sig_second;
		status_word[lmsc_pkg::ST_INSERT_BIT] = mod_r.insert;
		status_word[lmsc_pkg::ST_PORT_EN_BIT] = pins.signal_port_enable;
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		int_mask_nxt = int_mask_r;
		int_stat_nxt = int_stat_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		pready_nxt = setup;
		if (wr_take && paddr_in == lmsc_pkg::ADDR_CTRL) begin
			ctrl_nxt = 32'h00000000;
			ctrl_nxt[lmsc_pkg::CTRL_MOD_EN_BIT] = pwdata_in[lmsc_pkg::CTRL_MOD_EN_BIT];
		end
		if (wr_take && paddr_in == lmsc_pkg::ADDR_INT_MASK) begin
			int_mask_nxt = pwdata_in[lmsc_pkg::INT_W-1:0];
		end
		if (wr_take && paddr_in == lmsc_pkg::ADDR_INT_STAT) begin
			int_stat_nxt = int_stat_r & ~pwdata_in[lmsc_pkg::INT_W-1:0];
		end
		int_stat_nxt = int_stat_nxt | events;
		if (setup) begin
			pslverr_nxt = ~mapped;
			case (paddr_in)
				lmsc_pkg::ADDR_CTRL: prdata_nxt = ctrl_r;
				lmsc_pkg::ADDR_STATUS: prdata_nxt = status_word;
				lmsc_pkg::ADDR_INT_STAT: prdata_nxt = {{(32-lmsc_pkg::INT_W){1'b0}}, int_stat_r};
				lmsc_pkg::ADDR_INT_MASK: prdata_nxt = {{(32-lmsc_pkg::INT_W){1'b0}}, int_mask_r};
				default: prdata_nxt = 32'h00000000;
			endcase
		end
		irq_nxt = |(int_stat_nxt & int_mask_nxt);
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ctrl_r <= lmsc_pkg::CTRL_RESET;
			int_mask_r <= lmsc_pkg::INT_MASK_RESET;
			int_stat_r <= '0;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			int_mask_r <= int_mask_nxt;
			int_stat_r <= int_stat_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign prdata_out = prdata_r;
	assign pready_out = pready_r;
	assign pslverr_out = pslverr_r & pready_r;
	assign irq_out = irq_r;
	assign mod_out = mod_r;
	assign xfer_enable_out = xfer_en_r;
	assign sig_out = out_r;
	// Shared controller bus: outputs released while port disabled
	assign sig_oe_n_out.valid_indicator = ~pins.signal_port_enable;
	assign sig_oe_n_out.signal_out_first = ~pins.signal_port_enable;
	assign sig_oe_n_out.signal_out_second = ~pins.signal_port_enable;

endmodule : lmsc_top
`default_nettype wire

//--- lmsc_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module lmsc_chk (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [11:0] paddr_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire lmsc_pkg::lmsc_pins_t pins_in,
	input wire lmsc_pkg::lmsc_demod_t demod_in,
	input wire lmsc_pkg::lmsc_mod_t mod_out,
	input wire logic xfer_enable_out,
	input wire lmsc_pkg::lmsc_sig_t sig_out,
	input wire lmsc_pkg::lmsc_sig_t sig_oe_n_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	logic setup;
	logic bad;
	logic dn;
	assign setup = psel_in && !penable_in;
	assign bad = paddr_in[11:4] != 8'h00 || paddr_in[1:0] != 2'h0;
	assign dn = pins_in.signal_port_enable && !pins_in.power_down_bar;
	chk_ready_first: assert property (setup |=> pready_out) else $error("no ready after setup");
	chk_ready_only: assert property (pready_out |-> psel_in && penable_in && $past(setup)) else $error("stray ready");
	chk_err_unmapped: assert property (setup && bad |=> pslverr_out) else $error("unmapped not refused");
	chk_oe_off: assert property (!pins_in.signal_port_enable [*8] |-> sig_oe_n_out == 3'h7)
		else $error("outputs driven while disabled");
	chk_oe_on: assert property (pins_in.signal_port_enable [*8] |-> sig_oe_n_out == 3'h0)
		else $error("outputs not driven while enabled");
	chk_start_pulse: assert property (mod_out.start |=> !mod_out.start) else $error("start too long");
	chk_start_powered: assert property (mod_out.start |-> xfer_enable_out) else $error("burst while down");
	chk_down_quiet: assert property (dn [*8] |-> !mod_out.start && !xfer_enable_out)
		else $error("activity in power-down");
	chk_valid_good: assert property (dn [*8] ##0 demod_in.done && demod_in.sync_ok && !demod_in.bit_error
		|-> ##[1:2] sig_out.valid_indicator) else $error("valid not raised");
	chk_valid_bad: assert property (dn [*8] ##0 demod_in.done && (!demod_in.sync_ok || demod_in.bit_error)
		|-> ##[1:2] !sig_out.valid_indicator) else $error("valid on bad burst");
	chk_rx_down: assert property (dn [*8] ##0 demod_in.done && demod_in.sig_first
		|-> ##[1:2] sig_out.signal_out_first) else $error("rx bit not updated");
endmodule : lmsc_chk
`default_nettype wire

//--- lmsc_slave.sv
`timescale 1ns/1ns
`default_nettype none
module lmsc_slave #(parameter int DLY = 6) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire lmsc_pkg::lmsc_mod_t mod_in,
	input wire logic kick_in,
	input wire logic [3:0] cfg_in,
	output lmsc_pkg::lmsc_demod_t demod_out
);
	int cnt;
	bit [3:0] last;
	// Reply burst ends DLY cycles after a start or a forced burst
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt <= 0;
			last <= 4'h0;
		end else if (mod_in.start || kick_in) begin
			cnt <= DLY;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) last <= cfg_in;
		end
	end
	// Outside the done cycle the fields show the inverse of the last burst
	assign demod_out = (cnt == 1) ? {1'b1, cfg_in} : {1'b0, ~last};
endmodule : lmsc_slave
`default_nettype wire

//--- loop_master_signaling_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("ERROR %0t: %h vs %h", $time, a, b); end end
module loop_master_signaling_control_tb;
	localparam logic [32:0] ALL = 33'h1ffffffff;
	logic clk, rst, psel, pen, pwr, pready, pslverr, irq, xfer, kick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] cfg;
	logic [32:0] eq[$], mq[$], e, m;
	lmsc_pkg::lmsc_pins_t pins;
	lmsc_pkg::lmsc_demod_t demod;
	lmsc_pkg::lmsc_mod_t mod;
	lmsc_pkg::lmsc_sig_t sig, oe_n;
	int errors, n_tests, starts;
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	lmsc_top uut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.irq_out(irq), .pins_in(pins), .demod_in(demod), .mod_out(mod), .xfer_enable_out(xfer),
		.sig_out(sig), .sig_oe_n_out(oe_n));
	lmsc_slave #(.DLY(6)) slave (.clk_in(clk), .rst_in(rst), .mod_in(mod), .kick_in(kick), .cfg_in(cfg),
		.demod_out(demod));
	always @(posedge clk) begin
		if (mod.start === 1'b1) starts++;
		if (psel && pen && pready && !pwr) begin
			m = mq.pop_front();
			e = eq.pop_front();
			`CHK({pslverr, prdata} & m, e)
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] ex);
		int n;
		if (!w) eq.push_back(ex);
		if (!w) mq.push_back(ALL);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		n = 0;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20) begin
			errors++;
			$display("ERROR %0t: no bus answer", $time);
		end
		psel <= 0;
		pen <= 0;
	endtask : apb
	// Frame sync rises on a clock edge, as the data clock would
	task fs(input int k);
		repeat (k) begin
			@(posedge clk);
			pins.frame_sync <= 1;
			repeat (8) @(posedge clk);
			pins.frame_sync <= 0;
			repeat (16) @(posedge clk);
		end
	endtask : fs
	task dm(input logic [3:0] c);
		@(posedge clk);
		cfg <= c;
		kick <= 1;
		@(posedge clk);
		kick <= 0;
		repeat (12) @(posedge clk);
	endtask : dm
	task summarize;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	initial begin
		#200000;
		errors++;
		summarize();
	end
	initial begin
		logic [3:0] c, c2;
		logic [2:0] si;
		{rst, psel, pen, pwr, paddr, pwdata, pins, kick, cfg, errors, n_tests, starts} = '0;
		rst = 1;
		void'($urandom(26));
		repeat (16) @(posedge clk);
		rst <= 0;
		apb(0, lmsc_pkg::ADDR_CTRL, 32'h0, {1'b0, lmsc_pkg::CTRL_RESET});
		apb(0, lmsc_pkg::ADDR_INT_MASK, 32'h0, 33'h0);
		apb(0, 12'h010, 32'h0, 33'h100000000);
		`CHK(oe_n, 3'h7)
		pins.signal_port_enable <= 1;
		repeat (8) @(posedge clk);
		`CHK(oe_n, 3'h0)
		for (int i = 0; i < 4; i++) begin
			c = {i[1:0], 2'($urandom())};
			dm(c);
			`CHK(sig, {c[3] & !c[2], c[1:0]})
		end
		`CHK(starts, 0)
		`CHK(irq, 1'b0)
		apb(1, lmsc_pkg::ADDR_INT_MASK, 32'h2, 33'h0);
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b1)
		apb(1, lmsc_pkg::ADDR_INT_STAT, 32'h2, 33'h0);
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b0)
		si = 3'($urandom());
		c2 = {2'b10, ~c[1:0]};
		cfg <= c2;
		pins.power_down_bar <= 1;
		{pins.signal_in_first, pins.signal_in_second, pins.signal_insert_control} <= si;
		fs(3);
		`CHK(starts, 0)
		fs(1);
		`CHK(starts, 1)
		`CHK({mod.sig_first, mod.sig_second, mod.insert}, si)
		`CHK(sig, {1'b0, c[1:0]})
		fs(1);
		`CHK(sig, {1'b1, c2[1:0]})
		`CHK(starts, 2)
		pins.signal_port_enable <= 0;
		repeat (8) @(posedge clk);
		{pins.signal_in_first, pins.signal_in_second, pins.signal_insert_control} <= ~si;
		pins.power_down_bar <= 0;
		fs(1);
		`CHK({mod.sig_first, mod.sig_second, mod.insert}, si)
		`CHK(starts, 3)
		pins.signal_port_enable <= 1;
		repeat (8) @(posedge clk);
		fs(2);
		`CHK(starts, 3)
		`CHK(xfer, 1'b0)
		// Wake ended early by a slave burst, then one sync starts a burst
		pins.power_down_bar <= 1;
		repeat (8) @(posedge clk);
		dm(c2);
		fs(1);
		`CHK(starts, 4)
		`CHK(xfer, 1'b1)
		`CHK(eq.size(), 0)
		summarize();
	end
endmodule : loop_master_signaling_control_tb
bind lmsc_top lmsc_chk chk (.core_clk_in, .rst_in, .psel_in, .penable_in, .paddr_in, .pready_out, .pslverr_out,
	.pins_in, .demod_in, .mod_out, .xfer_enable_out, .sig_out, .sig_oe_n_out);
`default_nettype wire
